/* tb/adc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
    // clock
    input wire logic clk,
    // link pins driven by the host
    output logic selectN,
    output logic serialClock,
    // data pins from the device
    input wire logic oeA,
    input wire logic dA,
    input wire logic oeB,
    input wire logic dB
);
    logic [31:0] capA;
    logic [31:0] capB;
    //////////////////////////////
    // pins idle, clock stands low outside frames
    initial begin
        selectN = 1'b1;
        serialClock = 1'b0;
    end
    // one link half period of 160 ns
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // frame of n captured bits, n+1 rising edges
    task automatic frame(input int n);
        capA = 32'h0;
        capB = 32'h0;
        @(posedge clk);
        selectN <= 1'b0;
        half();
        serialClock <= 1'b1;
        half();
        for (int i = 0; i < n; i++) begin
            serialClock <= 1'b0;
            half();
            serialClock <= 1'b1;
            half();
            capA = {capA[30:0], oeA ? dA : 1'bx};
            capB = {capB[30:0], oeB ? dB : 1'bx};
        end
        serialClock <= 1'b0;
        half();
        selectN <= 1'b1;
        half();
        half();
    endtask
endmodule // adc_host_model
`default_nettype wire

/* tb/dual_adc_serial_readout_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module dual_adc_serial_readout_chk #(
    parameter int RES = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link pins
    input wire logic selectN,
    input wire logic channel_a_serial_out,
    input wire logic channelASerialOe,
    input wire logic channel_b_serial_out,
    input wire logic channelBSerialOe,
    // status
    input wire logic sampling,
    input wire logic frameDone,
    input wire logic frameAbort,
    input wire adc_readout_pkg::frame_state_e frameState,
    input wire logic [adc_readout_pkg::EDGE_CNT_W-1:0] riseEdgeCount
);
    import adc_readout_pkg::*;
    //////////////////////////////
    // frame steps seen at the pins
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence selFall; $fell(selectN); endsequence
    sequence selRise; $rose(selectN); endsequence
    sequence released; !channelASerialOe && !channelBSerialOe; endsequence
    sequence quiet; !channel_a_serial_out && !channel_b_serial_out; endsequence
    chk_start_zero: assert property (
        $rose(channelASerialOe) |-> quiet) else $error("start not zero");
    chk_fall_drives: assert property (
        selFall |-> ##[1:4] channelBSerialOe) else $error("not driven");
    chk_rise_release: assert property (
        selRise |-> ##[1:4] released) else $error("not released");
    chk_idle_quiet: assert property (
        frameState == FRAME_IDLE |-> released and quiet)
        else $error("idle pins busy");
    chk_done_count: assert property (
        frameDone |-> riseEdgeCount >= RES + 2) else $error("early done");
    chk_abort_short: assert property (
        frameAbort |-> riseEdgeCount < RES + 2 && sampling)
        else $error("bad abort");
    chk_conv_hold: assert property (
        $rose(frameState == FRAME_ACTIVE) |-> !sampling)
        else $error("sampling in frame");
    chk_pulse_once: assert property (
        frameDone || frameAbort |-> !(frameDone && frameAbort)
        ##1 !(frameDone || frameAbort)) else $error("bad end pulse");
endmodule // dual_adc_serial_readout_chk
bind dual_adc_serial_readout dual_adc_serial_readout_chk #(.RES(RES))
    dual_adc_serial_readout_chk_inst (.*);
`default_nettype wire

/* tb/dual_adc_serial_readout_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dual_adc_serial_readout_test;
    import adc_readout_pkg::*;
    localparam int RES = RESULT_BITS;
    logic clk, rst_n, selectN, serialClock, sampleValid, sampleReady;
    logic aOut, aOe, bOut, bOe, sampling, frameDone, frameAbort, frameUnderrun;
    logic [RES-1:0] sampleA, sampleB;
    frame_state_e frameState;
    logic [EDGE_CNT_W-1:0] riseEdgeCount;
    logic [71:0] expQ[$];
    logic [2*RES-1:0] sampQ[$];
    logic [71:0] seen;
    logic urSeen = 1'b0;
    logic acqSeen = 1'b0;
    logic acqQ[$];
    int n_errors, n_compared;
    int lens[8] = '{15, 17, 6, 1, 14, 16, 22, 15};
    integer seed = 32'hee0ce44d;
    //////////////////////////////
    dual_adc_serial_readout #(.RES(RES), .DEPTH(8))
        dual_adc_serial_readout_inst (
        .clk(clk), .rst_n(rst_n), .selectN(selectN), .serialClock(serialClock),
        .channel_a_serial_out(aOut), .channelASerialOe(aOe),
        .channel_b_serial_out(bOut), .channelBSerialOe(bOe),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .sampleA(sampleA), .sampleB(sampleB), .sampling(sampling),
        .frameDone(frameDone), .frameAbort(frameAbort),
        .frameUnderrun(frameUnderrun), .frameState(frameState),
        .riseEdgeCount(riseEdgeCount));
    adc_host_model adc_host_model_inst (.clk(clk), .selectN(selectN),
        .serialClock(serialClock), .oeA(aOe), .dA(aOut), .oeB(bOe), .dB(bOut));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    //////////////////////////////
    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bits captured: leading zero, result msb first, trailing zeros
    function automatic logic [31:0] exp32(input logic [RES-1:0] v,
        input int n);
        return {1'b0, v, {(31 - RES){1'b0}}} >> (32 - n);
    endfunction
    // note the expected outcome, then let the host run the frame
    task automatic run(input int n);
        logic [2*RES-1:0] s;
        logic ur;
        ur = (sampQ.size() == 0);
        s = ur ? '0 : sampQ.pop_front();
        expQ.push_back({ur, n + 1 >= RES + 2, 6'(n + 1),
            exp32(s[2*RES-1:RES], n), exp32(s[RES-1:0], n)});
        // the lsb launch ends conversion, sampling resumes inside the frame
        acqQ.push_back(n >= RES);
        adc_host_model_inst.frame(n);
    endtask
    //////////////////////////////
    // accepted samples, in queue order
    always @(posedge clk) begin
        if (rst_n && sampleValid && sampleReady)
            sampQ.push_back({sampleA, sampleB});
    end
    // compare each closed frame with the oldest note
    always @(posedge clk) begin
        if (frameUnderrun)
            urSeen <= 1'b1;
        if (sampling && frameState == FRAME_ACTIVE)
            acqSeen <= 1'b1;
        if (rst_n && (frameDone || frameAbort)) begin
            urSeen <= 1'b0;
            acqSeen <= 1'b0;
            seen = {urSeen, frameDone, riseEdgeCount,
                adc_host_model_inst.capA, adc_host_model_inst.capB};
            if (expQ.size() == 0) begin
                check(72'h1, 72'h0);
            end else begin
                check(seen, expQ.pop_front());
                check(72'(acqSeen), 72'(acqQ.pop_front()));
            end
        end
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        sampleValid = 1'b0;
        sampleA = '0;
        sampleB = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        run(15);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            sampleValid <= 1'b1;
            sampleA <= RES'($random(seed));
            sampleB <= RES'($random(seed));
        end
        @(posedge clk);
        sampleValid <= 1'b0;
        @(posedge clk);
        check(72'({sampleReady, 4'(sampQ.size())}), 72'h08);
        foreach (lens[i])
            run(lens[i]);
        repeat (10) @(posedge clk);
        check(72'({sampleReady, expQ.size() == 0}), 72'h3);
        finish_test();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end
endmodule // dual_adc_serial_readout_test
`default_nettype wire

/* verilog/adc_readout_pkg.sv */
`default_nettype none
package adc_readout_pkg;
    // result width of the larger variant, the smaller one uses 12
    localparam int RESULT_BITS = 14;
    // depth of the sample queue ahead of the shifter
    localparam int QUEUE_DEPTH = 8;
    // width of the edge counters, which saturate at 63 on longer frames
    localparam int EDGE_CNT_W = 6;
    // falling edge that carries the first result bit
    localparam logic [EDGE_CNT_W-1:0] FIRST_DATA_EDGE = 6'h02;
    // rising edges beyond the result width that complete a frame
    localparam logic [EDGE_CNT_W-1:0] EXTRA_RISE_EDGES = 6'h02;
    // reset value of the data outputs and their enables
    localparam logic SERIAL_OUT_RST = 1'b0;
    localparam logic SERIAL_OE_RST = 1'b0;

    // frame state of the readout shifter
    typedef enum logic {
        FRAME_IDLE,
        FRAME_ACTIVE
    } frame_state_e;
endpackage
`default_nettype wire

/* verilog/dual_adc_serial_readout.sv */
// Operation
// R1 - one select-low period is one frame
// R2 - select fall enables outputs driving zero
// R3 - host waits setup before first falling clock
// R4 - edge one zero, then MSB first
// R5 - zeros after last result bit
// R6 - sampling resumes once conversion completes
// R7 - select rise ends frame, outputs released
// R8 - wide variant needs sixteen rising edges
// R9 - narrow variant needs fourteen rising edges
// R10 - early select rise aborts, resumes sampling
// R11 - bits sent before abort stay valid
// R12 - host holds select high for acquisition
// R13 - results shift out as two's complement
// R14 - setup from select fall is 15 ns
// R15 - host captures on following rising edge
`timescale 1ns/10ps
`default_nettype none
module dual_adc_serial_readout #(
    parameter int RES = adc_readout_pkg::RESULT_BITS,
    parameter int DEPTH = adc_readout_pkg::QUEUE_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins from the host
    input wire logic selectN,
    input wire logic serialClock,
    // serial data pins, output and enable each
    output logic channel_a_serial_out,
    output logic channelASerialOe,
    output logic channel_b_serial_out,
    output logic channelBSerialOe,
    // converted samples in, two's complement per channel
    input wire logic sampleValid,
    output logic sampleReady,
    input wire logic [RES-1:0] sampleA,
    input wire logic [RES-1:0] sampleB,
    // status
    output logic sampling,
    output logic frameDone,
    output logic frameAbort,
    output logic frameUnderrun,
    output var adc_readout_pkg::frame_state_e frameState,
    output logic [adc_readout_pkg::EDGE_CNT_W-1:0] riseEdgeCount
);
    import adc_readout_pkg::*;

    localparam logic [EDGE_CNT_W-1:0] LAST_DATA_EDGE =
        EDGE_CNT_W'(RES) + FIRST_DATA_EDGE - 1'b1;
    localparam logic [EDGE_CNT_W-1:0] NEEDED_RISES =
        EDGE_CNT_W'(RES) + EXTRA_RISE_EDGES;
    localparam logic [EDGE_CNT_W-1:0] CNT_MAX = '1;

    typedef struct packed {
        logic [1:0] selSync;
        logic selPrev;
        logic [1:0] clkSync;
        logic clkPrev;
        frame_state_e state;
        logic [EDGE_CNT_W-1:0] fallCnt;
        logic [EDGE_CNT_W-1:0] riseCnt;
        logic [RES-1:0] shiftA;
        logic [RES-1:0] shiftB;
        logic outA;
        logic outB;
        logic oe;
        logic converting;
        logic done;
        logic abort;
        logic underrun;
        logic acquiring;
    } readout_s;

    readout_s st_r;
    readout_s st_nxt;
    logic [2*RES-1:0] queueOut;
    logic queueValid;
    logic queueReady;
    logic queueInReady;
    logic selFall;
    logic selRise;
    logic clkFall;
    logic clkRise;

    ////////////////////////////////////////////////////////////////////////
    // sample queue, drained one pair per frame start
    sample_fifo #(
        .WIDTH(2 * RES),
        .DEPTH(DEPTH)
    ) sample_fifo_inst (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(sampleValid),
        .inReady(queueInReady),
        .inData({sampleA, sampleB}),
        .outValid(queueValid),
        .outReady(queueReady),
        .outData(queueOut)
    );

    ////////////////////////////////////////////////////////////////////////
    // saturating edge counter step
    function automatic logic [EDGE_CNT_W-1:0] step(
        input logic [EDGE_CNT_W-1:0] c);
        step = (c == CNT_MAX) ? c : c + 1'b1;
    endfunction

    // edges seen on the synchronised pins, second stage onward only
    assign selFall = st_r.selPrev && !st_r.selSync[1];
    assign selRise = !st_r.selPrev && st_r.selSync[1];
    assign clkFall = st_r.clkPrev && !st_r.clkSync[1];
    assign clkRise = !st_r.clkPrev && st_r.clkSync[1];
    // a new sample is taken only as a frame opens
    assign queueReady = selFall && (st_r.state == FRAME_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer and shifters
    always_comb begin
        st_nxt = st_r;
        st_nxt.selSync = {st_r.selSync[0], selectN};
        st_nxt.selPrev = st_r.selSync[1];
        st_nxt.clkSync = {st_r.clkSync[0], serialClock};
        st_nxt.clkPrev = st_r.clkSync[1];
        st_nxt.done = 1'b0;
        st_nxt.abort = 1'b0;
        st_nxt.underrun = 1'b0;
        case (st_r.state)
            FRAME_IDLE: begin
                if (selFall) begin // [R1]
                    st_nxt.state = FRAME_ACTIVE;
                    st_nxt.oe = 1'b1; // [R2]
                    st_nxt.outA = 1'b0; // [R2]
                    st_nxt.outB = 1'b0;
                    st_nxt.fallCnt = '0;
                    st_nxt.riseCnt = '0;
                    st_nxt.converting = 1'b1;
                    // results pass through unchanged, two's complement
                    if (queueValid) begin // [R13]
                        st_nxt.shiftA = queueOut[2*RES-1:RES];
                        st_nxt.shiftB = queueOut[RES-1:0];
                    end else begin
                        st_nxt.shiftA = '0;
                        st_nxt.shiftB = '0;
                        st_nxt.underrun = 1'b1;
                    end
                end
            end
            FRAME_ACTIVE: begin
                if (selRise) begin
                    // frame closes, pins released at once
                    st_nxt.state = FRAME_IDLE; // [R7]
                    st_nxt.oe = 1'b0; // [R7]
                    st_nxt.outA = 1'b0;
                    st_nxt.outB = 1'b0;
                    st_nxt.converting = 1'b0; // [R10]
                    if (st_r.riseCnt < NEEDED_RISES) begin // [R8] [R9]
                        st_nxt.abort = 1'b1; // [R10] [R11]
                    end else begin
                        st_nxt.done = 1'b1;
                    end
                end else begin
                    if (clkFall) begin
                        st_nxt.fallCnt = step(st_r.fallCnt);
                        if (st_nxt.fallCnt >= FIRST_DATA_EDGE &&
                            st_nxt.fallCnt <= LAST_DATA_EDGE) begin
                            st_nxt.outA = st_r.shiftA[RES-1]; // [R4]
                            st_nxt.outB = st_r.shiftB[RES-1];
                            st_nxt.shiftA = {st_r.shiftA[RES-2:0], 1'b0};
                            st_nxt.shiftB = {st_r.shiftB[RES-2:0], 1'b0};
                        end else begin
                            st_nxt.outA = 1'b0; // [R4] [R5]
                            st_nxt.outB = 1'b0; // [R5]
                        end
                        if (st_nxt.fallCnt == LAST_DATA_EDGE) begin
                            st_nxt.converting = 1'b0; // [R6]
                        end
                    end
                    if (clkRise) begin
                        st_nxt.riseCnt = step(st_r.riseCnt);
                    end
                end
            end
            default: begin
                st_nxt.state = FRAME_IDLE;
                st_nxt.oe = 1'b0;
            end
        endcase
        // acquisition flag tracks conversion, registered for the pin
        st_nxt.acquiring = !st_nxt.converting; // [R6]
    end

    // state register, select idles high, clock idles low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{selSync: 2'h3, selPrev: 1'b1, clkSync: 2'h0,
                      clkPrev: 1'b0, state: FRAME_IDLE, fallCnt: '0,
                      riseCnt: '0, shiftA: '0, shiftB: '0,
                      outA: SERIAL_OUT_RST, outB: SERIAL_OUT_RST,
                      oe: SERIAL_OE_RST, converting: 1'b0, done: 1'b0,
                      abort: 1'b0, underrun: 1'b0, acquiring: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign channel_a_serial_out = st_r.outA;
    assign channel_b_serial_out = st_r.outB;
    assign channelASerialOe = st_r.oe;
    assign channelBSerialOe = st_r.oe;
    assign sampleReady = queueInReady; // flop inside the queue
    assign sampling = st_r.acquiring; // [R6]
    assign frameDone = st_r.done;
    assign frameAbort = st_r.abort;
    assign frameUnderrun = st_r.underrun;
    assign frameState = st_r.state;
    assign riseEdgeCount = st_r.riseCnt;
endmodule // dual_adc_serial_readout
`default_nettype wire

/* verilog/sample_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = adc_readout_pkg::QUEUE_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    import adc_readout_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
        logic full;
        logic empty;
        logic notFull;
    } fifo_s;

    fifo_s st_r;
    fifo_s st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    ////////////////////////////////////////////////////////////////////////
    // handshakes, flags come straight from flops
    assign doPush = inValid && !st_r.full;
    assign doPop = outReady && !st_r.empty;
    assign inReady = st_r.notFull;
    assign outValid = !st_r.empty;
    assign outData = mem[st_r.rdPtr];

    // pointer wrap for any depth
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST_C) ? '0 : p + 1'b1;
    endfunction

    // next pointers and flags
    always_comb begin
        st_nxt = st_r;
        if (doPush) begin
            st_nxt.wrPtr = bump(st_r.wrPtr);
        end
        if (doPop) begin
            st_nxt.rdPtr = bump(st_r.rdPtr);
        end
        case ({doPush, doPop})
            2'b10: st_nxt.count = st_r.count + 1'b1;
            2'b01: st_nxt.count = st_r.count - 1'b1;
            default: st_nxt.count = st_r.count;
        endcase
        st_nxt.full = (st_nxt.count == DEPTH_C);
        st_nxt.empty = (st_nxt.count == '0);
        st_nxt.notFull = !st_nxt.full;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{wrPtr: '0, rdPtr: '0, count: '0, full: 1'b0,
                      empty: 1'b1, notFull: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[st_r.wrPtr] <= inData;
        end
    end
endmodule // sample_fifo
`default_nettype wire
